// ==== tb_top.sv ====
// Purpose: self-checking bench for the vertical timebase
// Assumes: ahb-lite master waits on hreadyout, never counts cycles
// Notes:   short integrator and six-clock half-lines keep runs brief
`include "vtb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] A_CTRL = {24'h0, `VTB_CTRL_OFS};
	localparam logic [31:0] A_STAT = {24'h0, `VTB_STAT_OFS};
	localparam logic [31:0] A_GEO  = {24'h0, `VTB_GEO_OFS};
	logic              clk_sys = 1'b0;
	logic              rst = 1'b1;
	logic              hsel = 1'b0;
	logic [31:0]       haddr = 32'h0;
	logic [1:0]        htrans = 2'h0;
	logic              hwrite = 1'b0;
	logic [31:0]       hwdata = 32'h0;
	logic              en = 1'b0;
	logic              h_bad = 1'b0;
	logic              to_aux = 1'b0;
	logic [1:0]        beam = 2'h0;
	logic [9:0]        src_len = 10'h271;
	logic [9:0]        lcnt = 10'h0;
	logic [9:0]        last_len = 10'h0;
	logic              lp_d = 1'b0;
	int                failures = 0;
	int                n_checks = 0;
	wire               hreadyout;
	wire               hresp;
	wire [31:0]        hrdata;
	wire               cs;
	wire               line_pulse;
	wire               hsync_in;
	wire               hloop_fh;
	wire               vsync_out;
	wire               vblank;
	wire               std525;
	wire               cd_flag;
	wire               h_unlock;
	wire               ila;
	wire               ilb;
	wire [8:0]         v_amp_eff;
	vtb_pkg::vtb_geo_t geo_o [1:7];

	always #5 clk_sys = ~clk_sys;

	vtb_sync_model src (
		.clk_sys(clk_sys), .en(en), .h_bad(h_bad), .field_len(src_len),
		.csync(cs), .line_pulse(line_pulse), .hsync_in(hsync_in),
		.hloop_fh(hloop_fh)
	);

	vtb_vertical_timebase #(.AUX_N(2), .INT_W(4), .INT_THR(3)) uut (
		.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .csync_main(cs & ~to_aux),
		.csync_aux({1'b0, cs & to_aux}), .line_pulse(line_pulse),
		.hsync_in(hsync_in), .hloop_fh(hloop_fh), .beam_thr1(beam[0]),
		.beam_thr2(beam[1]), .vsync_out(vsync_out), .vblank(vblank),
		.std525(std525), .countdown_flag(cd_flag), .h_unlock(h_unlock),
		.interlace_ctrl_a(ila), .interlace_ctrl_b(ilb),
		.v_amp_eff(v_amp_eff), .v_lin(geo_o[1]), .v_breath(geo_o[2]),
		.v_pos(geo_o[3]), .ew_amp(geo_o[4]), .h_amp(geo_o[5]),
		.corner(geo_o[6]), .tilt(geo_o[7])
	);

	// field length from the line pulses the source really sent
	always @(posedge clk_sys)
	begin
		lp_d <= line_pulse;
		if (vsync_out)
			last_len <= lcnt;
		if (vsync_out)
			lcnt <= {9'h0, line_pulse & ~lp_d};
		else
			lcnt <= lcnt + {9'h0, line_pulse & ~lp_d};
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic xfer(input logic wr, input logic [31:0] a, wd,
		output logic [31:0] rd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : xfer

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask : wr

	task automatic rdc(input string what, input logic [31:0] a, m, exp);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0, x);
		chk(what, exp, x & m);
	endtask : rdc

	task automatic wait_vs;
		int i;
		i = 0;
		do
		begin
			@(posedge clk_sys);
			i++;
		end
		while (vsync_out !== 1'b1 && i < 6000);
		chk("vsync wait", 32'h1, {31'h0, vsync_out});
	endtask : wait_vs

	// first two fields after a change may be partial
	task automatic measure(input string what, input logic [9:0] exp);
		repeat (3) wait_vs;
		@(negedge clk_sys);
		chk(what, {22'h0, exp}, {22'h0, last_len});
	endtask : measure

	task automatic bpulse(input logic [1:0] b);
		@(posedge clk_sys);
		beam <= b;
		repeat (4) @(posedge clk_sys);
		beam <= 2'h0;
	endtask : bpulse

	initial
	begin
		// longest clean run is about 78k cycles; stay under the 99k budget
		repeat (99000) @(posedge clk_sys);
		failures++;
		end_sim;
	end

	initial
	begin : main
		int          n;
		logic [5:0]  g;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rdc("ctrl reset", A_CTRL, 32'hffffffff, 32'h0);
		rdc("status reset", A_STAT, 32'h3ff, 32'h20);
		rdc("unmapped read", 32'h40, 32'hffffffff, 32'h0);
		chk("vblank", 32'h1, {31'h0, vblank});
		$display("test reset done");
		en <= 1'b1;
		wr(A_CTRL, 32'h1);
		n = 0;
		do
		begin
			wait_vs;
			@(negedge clk_sys);
			n++;
		end
		while (cd_flag !== 1'b1 && n < 12);
		chk("fields to countdown", 32'h8, n);
		rdc("lock at countdown", A_STAT, 32'h21f, 32'h218);
		rdc("h locked", A_STAT, 32'h20, 32'h0);
		h_bad <= 1'b1;
		repeat (300) @(posedge clk_sys);
		chk("h unlock", 32'h1, {31'h0, h_unlock});
		chk("countdown kept", 32'h1, {31'h0, cd_flag});
		h_bad <= 1'b0;
		wait_vs;
		rdc("lock up", A_STAT, 32'hf, 32'h9);
		src_len <= 10'h258;
		wait_vs;
		rdc("lock down", A_STAT, 32'h21f, 32'h218);
		// jump keeps auto set, so recapture is automatic
		wr(A_CTRL, 32'h3);
		rdc("jump to injection", A_STAT, 32'h200, 32'h0);
		rdc("jump bit clears", A_CTRL, 32'hffffffff, 32'h1);
		$display("test countdown done");
		for (int i = 0; i < 8; i++)
		begin
			g = 6'h28 + 6'(i * 3);
			wr(A_GEO + 32'(4 * i), {26'h3ffffff, g});
		end
		for (int i = 0; i < 8; i++)
		begin
			g = 6'h28 + 6'(i * 3);
			rdc("geometry", A_GEO + 32'(4 * i), 32'hffffffff, {26'h0, g});
			if (i > 0)
				chk("geometry port", {26'h0, g}, {26'h0, geo_o[i]});
		end
		wr(32'h40, 32'h3f);
		rdc("unmapped write", 32'h40, 32'hffffffff, 32'h0);
		chk("height", 32'd160, {23'h0, v_amp_eff});
		$display("test geometry done");
		wr(A_CTRL, 32'h1c0);
		repeat (3) @(negedge clk_sys);
		chk("interlace a", 32'h1, {31'h0, ila});
		chk("interlace b", 32'h1, {31'h0, ilb});
		chk("height reduced", 32'd120, {23'h0, v_amp_eff});
		wr(A_CTRL, 32'h80);
		repeat (3) @(negedge clk_sys);
		chk("interlace a off", 32'h0, {31'h0, ila});
		chk("interlace b on", 32'h1, {31'h0, ilb});
		chk("height restored", 32'd160, {23'h0, v_amp_eff});
		$display("test control done");
		for (int k = 1; k < 3; k++)
		begin
			bpulse(2'(k));
			rdc("beam flag", A_STAT, 32'hc0, 32'(k) << 6);
			wr(A_STAT, 32'(k) << 6);
			rdc("beam cleared", A_STAT, 32'hc0, 32'h0);
		end
		$display("test beam done");
		to_aux <= 1'b1;
		src_len <= 10'h12c;
		wr(A_CTRL, 32'h200);
		measure("injection window", 10'd600);
		wr(A_CTRL, 32'h0);
		measure("free run", 10'd740);
		wr(A_CTRL, 32'h10);
		measure("free run 100", 10'd370);
		src_len <= 10'h271;
		wr(A_CTRL, 32'h208);
		measure("forced 525", 10'd525);
		chk("std525", 32'h1, {31'h0, std525});
		chk("height 525", 32'd192, {23'h0, v_amp_eff});
		$display("test field length done");
		end_sim;
	end
endmodule : tb_top
`default_nettype wire

// ==== vtb_cfg.svh ====
// Purpose: constants of the vertical timebase block
// Assumes: 100 MHz system clock, one aligned 32-bit word per register
// Notes:   line counts are in half-line pulses (2x line rate)
`ifndef VTB_CFG_SVH
`define VTB_CFG_SVH

// register byte offsets
`define VTB_CTRL_OFS   8'h00
`define VTB_STAT_OFS   8'h04
`define VTB_GEO_OFS    8'h08
`define VTB_GEO_LAST   8'h24

// control register fields
`define VTB_C_AUTO     0
`define VTB_C_INJ      1
`define VTB_C_FORCE    2
`define VTB_C_RATE     4
`define VTB_C_BLANK    5
`define VTB_C_ILA      6
`define VTB_C_ILB      7
`define VTB_C_VRED     8
`define VTB_C_SSEL     9
`define VTB_CTRL_W     11
`define VTB_CTRL_RST   11'h000

// status register fields
`define VTB_S_MODE     9
`define VTB_S_EXC      6
`define VTB_S_OVL      7
`define VTB_S_LINE     16

// forced line count codes
`define VTB_F_OFF      2'h0
`define VTB_F_625      2'h1
`define VTB_F_525      2'h2

// line-count decodes, normal and double rate
`define VTB_LINE_MIN   10'h1c0
`define VTB_LINE_MAX   10'h2e4
`define VTB_MIN_100    10'h0e0
`define VTB_MAX_100    10'h172
`define VTB_EXP_625    10'h271
`define VTB_EXP_525    10'h20d
`define VTB_E625_100   10'h138
`define VTB_E525_100   10'h106
`define VTB_BLANK_625  10'h032
`define VTB_BLANK_525  10'h02a

// height factors in tenths
`define VTB_HF_NORM    6'h28
`define VTB_HF_525     6'h30
`define VTB_HF_RED     6'h1e
`define VTB_HF_BOTH    6'h24
`define VTB_HF_DIV     15'h00a

// timing
`define VTB_CLK_NS     10
`define VTB_INT_NS     20000
`define VTB_INT_CYC    (`VTB_INT_NS / `VTB_CLK_NS)
`define VTB_HWIN_NS    1000
`define VTB_HWIN_CYC   (`VTB_HWIN_NS / `VTB_CLK_NS)

`endif

// ==== vtb_pkg.sv ====
// Purpose: types of the vertical timebase block
// Assumes: constants live in vtb_cfg.svh
// Notes:   none
`default_nettype none
package vtb_pkg;
	typedef enum logic [1:0] {ST_INJ, ST_CD, ST_FORCED} vtb_mode_e;
	typedef logic [5:0] vtb_geo_t;
endpackage : vtb_pkg
`default_nettype wire

// ==== vtb_sync_model.sv ====
// Purpose: composite sync source and horizontal loop model
// Assumes: half-line period of six clocks, three of them high
// Notes:   a field starts with a twelve-clock broad pulse on csync
`timescale 1ns/1ps
`default_nettype none
module vtb_sync_model (
	// control from the bench
	input  wire logic       clk_sys,
	input  wire logic       en,
	input  wire logic       h_bad,
	input  wire logic [9:0] field_len,
	// video pins
	output logic            csync,
	output logic            line_pulse,
	output logic            hsync_in,
	output logic            hloop_fh
);
	logic [2:0] ph;
	logic [9:0] cnt;
	logic [3:0] bc;
	logic       start;

	// >= so a shortened field never skips its pulse
	assign start = en && ph == 3'h0 && cnt + 10'h001 >= field_len;

	initial
	begin
		csync = 1'b0;
		line_pulse = 1'b0;
		hsync_in = 1'b0;
		hloop_fh = 1'b0;
	end

	always @(posedge clk_sys)
	begin
		ph <= (!en || ph == 3'h5) ? 3'h0 : ph + 3'h1;
		line_pulse <= en && ph < 3'h3;
		hloop_fh <= en && ph < 3'h2 && cnt[0];
		hsync_in <= en && !h_bad && ph < 3'h2 && cnt[0];
		csync <= start || bc > 4'h1;
		if (!en || start)
			cnt <= 10'h000;
		else if (ph == 3'h0)
			cnt <= cnt + 10'h001;
		if (!en)
			bc <= 4'h0;
		else if (start)
			bc <= 4'hc;
		else if (bc != 4'h0)
			bc <= bc - 4'h1;
	end
endmodule : vtb_sync_model
`default_nettype wire

// ==== vtb_vertical_timebase.sv ====
// Purpose: digital vertical timebase with countdown lock supervisor
// Assumes: ahb-lite single word transfers, zero wait states
// Notes:   all pins pass a two-stage synchroniser
// Function
// - integrating counter counts up on sync high, down on sync low
// - vertical sync only when integrator reaches threshold during broad pulses
// - auto countdown starts in injection lock, locking to first sync
// - each field with expected line count increments 4-bit lock counter
// - eight coincidences engage countdown; counter msb is countdown flag
// - non-coincidence decrements; reaching zero reverts to injection lock
// - host command jumps to injection lock at once; auto bit is kept as written
// - injection lock ignores vertical sync before line 448
// - line counter resets itself at line 740 without sync
// - 100 Hz mode scales end-stops; no 120 Hz decodes exist
// - forced 625 or 525 count ignores incoming sync entirely
// - recognised 525 standard multiplies height by 1.2
// - reduce bit scales vertical amplitude to 75 percent
// - eight geometry adjustments each held as 6-bit host latch
// - beam current threshold one and two raise separate flags
// - control bit selects 525 or 625 vertical blanking count
// - two host bits suppress interlace
// - countdown and horizontal lock flags detected independently
// - vertical separator sync selectable from main or any aux input
// - horizontal loop compared with incoming sync, out-of-lock flag
`include "vtb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vtb_vertical_timebase #(
	parameter int AUX_N   = 2,
	parameter int INT_W   = 12,
	parameter int INT_THR = `VTB_INT_CYC
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// ahb-lite slave
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	// video pins
	input  wire logic             csync_main,
	input  wire logic [AUX_N-1:0] csync_aux,
	input  wire logic             line_pulse,
	input  wire logic             hsync_in,
	input  wire logic             hloop_fh,
	input  wire logic             beam_thr1,
	input  wire logic             beam_thr2,
	// timebase state
	output logic                  vsync_out,
	output logic                  vblank,
	output logic                  std525,
	output logic                  countdown_flag,
	output logic                  h_unlock,
	output logic                  interlace_ctrl_a,
	output logic                  interlace_ctrl_b,
	// geometry
	output logic [8:0]            v_amp_eff,
	output vtb_pkg::vtb_geo_t     v_lin,
	output vtb_pkg::vtb_geo_t     v_breath,
	output vtb_pkg::vtb_geo_t     v_pos,
	output vtb_pkg::vtb_geo_t     ew_amp,
	output vtb_pkg::vtb_geo_t     h_amp,
	output vtb_pkg::vtb_geo_t     corner,
	output vtb_pkg::vtb_geo_t     tilt
);
	localparam int PW = AUX_N + 6;

	// sel: 0 min stop, 1 max stop, 2 count 625, 3 count 525
	function automatic logic [9:0] vtb_lines(input logic rate,
		input logic [1:0] sel);
		logic [9:0] v;
		v = 10'h000;
		unique case (sel)
			2'h0: v = rate ? `VTB_MIN_100 : `VTB_LINE_MIN;
			2'h1: v = rate ? `VTB_MAX_100 : `VTB_LINE_MAX;
			2'h2: v = rate ? `VTB_E625_100 : `VTB_EXP_625;
			2'h3: v = rate ? `VTB_E525_100 : `VTB_EXP_525;
		endcase
		return v;
	endfunction : vtb_lines

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// pin synchroniser; first stage feeds only the second
	logic [PW-1:0] pin_meta;
	logic [PW-1:0] pin_s;
	logic [PW-1:0] pin_q;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pin_meta <= '0;
			pin_s    <= '0;
			pin_q    <= '0;
		end
		else
		begin
			pin_meta <= {csync_aux, csync_main, line_pulse, hsync_in,
				hloop_fh, beam_thr1, beam_thr2};
			pin_s    <= pin_meta;
			pin_q    <= pin_s;
		end
	end

	logic             thr2_s;
	logic             thr1_s;
	logic             fh_ev;
	logic             hs_ev;
	logic             lp_ev;
	logic [AUX_N:0]   csync_s;
	assign thr2_s  = pin_s[0];
	assign thr1_s  = pin_s[1];
	assign fh_ev   = pin_s[2] & ~pin_q[2];
	assign hs_ev   = pin_s[3] & ~pin_q[3];
	assign lp_ev   = pin_s[4] & ~pin_q[4];
	assign csync_s = pin_s[PW-1:5];

	// ahb-lite slave and host latches
	logic [`VTB_CTRL_W-1:0] ctrl;
	logic [`VTB_CTRL_W-1:0] next_ctrl;
	vtb_pkg::vtb_geo_t      geo [8];
	vtb_pkg::vtb_geo_t      next_geo [8];
	logic                   inj_pulse;
	logic                   next_inj;
	logic                   wr_pend;
	logic                   next_wr_pend;
	logic [7:0]             wr_addr;
	logic [7:0]             next_wr_addr;
	logic [31:0]            next_hrdata;
	logic                   clr_exc;
	logic                   clr_ovl;
	logic [7:0]             goff;
	logic                   beam_exc;
	logic                   beam_ovl;
	logic [3:0]             lock;
	logic [9:0]             line_cnt;
	vtb_pkg::vtb_mode_e     mode;
	logic [1:0]             force_sel;
	logic                   rate100;

	assign force_sel = ctrl[`VTB_C_FORCE +: 2];
	assign rate100   = ctrl[`VTB_C_RATE];

	always_comb
	begin
		next_wr_pend = hsel && hready && htrans[1] && hwrite;
		next_wr_addr = haddr[31:8] == 24'h000000 ? haddr[7:0] : 8'hff;
		next_hrdata  = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite
			&& haddr[31:8] == 24'h000000)
		begin
			if (haddr[7:0] == `VTB_CTRL_OFS)
				next_hrdata = {21'h000000, ctrl};
			else if (haddr[7:0] == `VTB_STAT_OFS)
				next_hrdata = {6'h00, line_cnt, 6'h00,
					mode == vtb_pkg::ST_CD, std525, beam_ovl, beam_exc,
					h_unlock, lock[3], lock};
			else if (haddr[7:0] >= `VTB_GEO_OFS
				&& haddr[7:0] <= `VTB_GEO_LAST && haddr[1:0] == 2'h0)
				next_hrdata = {26'h0000000,
					geo[3'((haddr[7:0] - `VTB_GEO_OFS) >> 2)]};
		end
		next_ctrl = ctrl;
		next_inj  = 1'b0;
		next_geo  = geo;
		clr_exc   = 1'b0;
		clr_ovl   = 1'b0;
		goff      = 8'(wr_addr - `VTB_GEO_OFS);
		if (wr_pend)
		begin
			if (wr_addr == `VTB_CTRL_OFS)
			begin
				// jump command is a pulse and reads back zero
				next_ctrl = hwdata[`VTB_CTRL_W-1:0];
				next_ctrl[`VTB_C_INJ] = 1'b0;
				next_inj  = hwdata[`VTB_C_INJ];
			end
			if (wr_addr == `VTB_STAT_OFS)
			begin
				clr_exc = hwdata[`VTB_S_EXC];
				clr_ovl = hwdata[`VTB_S_OVL];
			end
			if (wr_addr >= `VTB_GEO_OFS && wr_addr <= `VTB_GEO_LAST
				&& wr_addr[1:0] == 2'h0)
				next_geo[goff[4:2]] = hwdata[5:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			ctrl      <= `VTB_CTRL_RST;
			inj_pulse <= 1'b0;
			geo       <= '{default: 6'h00};
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= next_hrdata;
			wr_pend   <= next_wr_pend;
			wr_addr   <= next_wr_addr;
			ctrl      <= next_ctrl;
			inj_pulse <= next_inj;
			geo       <= next_geo;
		end
	end

	// vertical sync integrator
	logic [INT_W-1:0] int_cnt;
	logic [INT_W-1:0] next_int;
	logic             vs_lvl;
	logic             next_vs_lvl;
	logic             vs_ev;
	logic             sync_hi;
	// a select beyond the fitted inputs reads as no sync, never unknown
	assign sync_hi = (int'(ctrl[`VTB_C_SSEL +: 2]) <= AUX_N)
		&& csync_s[ctrl[`VTB_C_SSEL +: 2]];

	always_comb
	begin
		next_int = int_cnt;
		if (sync_hi && int_cnt != {INT_W{1'b1}})
			next_int = int_cnt + 1'b1;
		else if (!sync_hi && int_cnt != '0)
			next_int = int_cnt - 1'b1;
		next_vs_lvl = int_cnt >= INT_W'(INT_THR);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			int_cnt <= '0;
			vs_lvl  <= 1'b0;
		end
		else
		begin
			int_cnt <= next_int;
			vs_lvl  <= next_vs_lvl;
		end
	end
	assign vs_ev = next_vs_lvl && !vs_lvl;

	integ_up_a: assert property (sync_hi && int_cnt != {INT_W{1'b1}}
		|=> int_cnt == $past(int_cnt) + 1'b1)
		else $error("integrator did not count up");
	vs_thresh_a: assert property (vs_ev |-> int_cnt >= INT_W'(INT_THR))
		else $error("vertical sync below threshold");

	// line counter and lock supervisor
	vtb_pkg::vtb_mode_e next_mode;
	logic [9:0]         next_line;
	logic [3:0]         next_lock;
	logic               next_std;
	logic               next_vsync;
	logic               next_vblank;
	logic               end_f;
	logic               judge;
	logic               coin;
	logic [9:0]         exp_l;
	logic [9:0]         fexp;

	always_comb
	begin
		next_mode  = mode;
		next_lock  = lock;
		next_std   = std525;
		end_f      = 1'b0;
		judge      = 1'b0;
		coin       = 1'b0;
		exp_l      = vtb_lines(rate100, {1'b1, std525});
		fexp       = vtb_lines(rate100, {1'b1, force_sel == `VTB_F_525});
		next_line  = lp_ev ? line_cnt + 10'h001 : line_cnt;
		unique case (mode)
			vtb_pkg::ST_FORCED:
				// sync ignored: free count to the forced length
				if (lp_ev && line_cnt >= fexp - 10'h001)
					end_f = 1'b1;
			vtb_pkg::ST_INJ:
				if (vs_ev && line_cnt >= vtb_lines(rate100, 2'h0))
				begin
					end_f = 1'b1;
					judge = 1'b1;
					coin  = line_cnt == vtb_lines(rate100, 2'h2)
						|| line_cnt == vtb_lines(rate100, 2'h3);
					if (coin)
						next_std = line_cnt == vtb_lines(rate100, 2'h3);
				end
				else if (line_cnt >= vtb_lines(rate100, 2'h1))
				begin
					end_f = 1'b1;
					judge = 1'b1;
				end
			vtb_pkg::ST_CD:
				if (vs_ev && line_cnt == exp_l)
				begin
					end_f = 1'b1;
					judge = 1'b1;
					coin  = 1'b1;
				end
				else if (lp_ev && line_cnt >= exp_l)
				begin
					// flywheel on, sync missed or misplaced
					end_f = 1'b1;
					judge = 1'b1;
				end
		endcase
		if (end_f)
			next_line = 10'h000;
		if (judge && coin && lock != 4'hf)
			next_lock = lock + 4'h1;
		else if (judge && !coin && lock != 4'h0)
			next_lock = lock - 4'h1;
		if (ctrl[`VTB_C_AUTO] && next_lock[3] && judge && coin)
			next_mode = vtb_pkg::ST_CD;
		if (next_lock == 4'h0 || !ctrl[`VTB_C_AUTO])
			next_mode = vtb_pkg::ST_INJ;
		if (inj_pulse)
		begin
			next_mode = vtb_pkg::ST_INJ;
			next_lock = 4'h0;
		end
		if (force_sel != `VTB_F_OFF)
		begin
			next_mode = vtb_pkg::ST_FORCED;
			next_std  = force_sel == `VTB_F_525;
		end
		next_vsync  = end_f;
		next_vblank = next_line < (ctrl[`VTB_C_BLANK] ?
			`VTB_BLANK_525 : `VTB_BLANK_625);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			mode      <= vtb_pkg::ST_INJ;
			line_cnt  <= 10'h000;
			lock      <= 4'h0;
			std525    <= 1'b0;
			vsync_out <= 1'b0;
			vblank    <= 1'b1;
		end
		else
		begin
			mode      <= next_mode;
			line_cnt  <= next_line;
			lock      <= next_lock;
			std525    <= next_std;
			vsync_out <= next_vsync;
			vblank    <= next_vblank;
		end
	end
	assign countdown_flag = lock[3];

	sequence s_field_restart;
		##1 line_cnt == 10'h000 ##0 vsync_out;
	endsequence
	field_reset_a: assert property (end_f |-> s_field_restart)
		else $error("field end did not restart line count");
	inj_jump_a: assert property (inj_pulse && force_sel == `VTB_F_OFF
		|=> mode == vtb_pkg::ST_INJ && lock == 4'h0)
		else $error("jump to injection lock failed");
	lock_inc_a: assert property (judge && coin && lock != 4'hf && !inj_pulse
		|=> lock == $past(lock) + 4'h1)
		else $error("lock counter missed a coincidence");
	cd_engage_a: assert property (mode == vtb_pkg::ST_INJ && judge && coin
		&& lock == 4'h7 && ctrl[`VTB_C_AUTO] && !inj_pulse
		&& force_sel == `VTB_F_OFF |=> mode == vtb_pkg::ST_CD
		&& countdown_flag)
		else $error("countdown not engaged at eight");
	revert_inj_a: assert property (judge && !coin && lock == 4'h1
		&& force_sel == `VTB_F_OFF |=> lock == 4'h0
		&& mode == vtb_pkg::ST_INJ)
		else $error("no return to injection lock");
	lock_sat_a: assert property (lock == 4'hf && judge && coin && !inj_pulse
		|=> lock == 4'hf)
		else $error("lock counter wrapped");
	min_stop_a: assert property (mode == vtb_pkg::ST_INJ && vs_ev
		&& line_cnt < vtb_lines(rate100, 2'h0) && !lp_ev
		|=> line_cnt == $past(line_cnt))
		else $error("early sync accepted in injection lock");
	max_stop_a: assert property (mode == vtb_pkg::ST_INJ
		&& line_cnt >= vtb_lines(rate100, 2'h1) |=> line_cnt == 10'h000)
		else $error("max end-stop did not reset");
	forced_len_a: assert property (mode == vtb_pkg::ST_FORCED
		|-> line_cnt <= `VTB_EXP_625)
		else $error("forced count overran");

	// horizontal coincidence, separate from the vertical lock
	logic [7:0] hcnt;
	logic [7:0] next_hcnt;
	logic       next_hunl;
	always_comb
	begin
		next_hcnt = hcnt;
		if (hs_ev)
			next_hcnt = 8'h00;
		else if (hcnt != 8'hff)
			next_hcnt = hcnt + 8'h01;
		next_hunl = h_unlock;
		if (fh_ev)
			next_hunl = hcnt > 8'(`VTB_HWIN_CYC);
		else if (hcnt == 8'hff)
			next_hunl = 1'b1;
	end

	// beam flags are sticky; a new event beats a host clear
	logic next_exc;
	logic next_ovl;
	always_comb
	begin
		next_exc = thr1_s || (beam_exc && !clr_exc);
		next_ovl = thr2_s || (beam_ovl && !clr_ovl);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hcnt     <= 8'h00;
			h_unlock <= 1'b1;
			beam_exc <= 1'b0;
			beam_ovl <= 1'b0;
		end
		else
		begin
			hcnt     <= next_hcnt;
			h_unlock <= next_hunl;
			beam_exc <= next_exc;
			beam_ovl <= next_ovl;
		end
	end

	beam_flag_a: assert property (thr1_s |=> beam_exc [*1] ##0 $past(thr1_s))
		else $error("beam flag not raised");

	// geometry outputs
	logic [5:0] hfac;
	logic [8:0] next_vamp;
	always_comb
	begin
		unique case ({ctrl[`VTB_C_VRED], std525})
			2'b00: hfac = `VTB_HF_NORM;
			2'b01: hfac = `VTB_HF_525;
			2'b10: hfac = `VTB_HF_RED;
			2'b11: hfac = `VTB_HF_BOTH;
		endcase
		next_vamp = 9'((15'(geo[0]) * 15'(hfac)) / `VTB_HF_DIV);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			v_amp_eff        <= 9'h000;
			interlace_ctrl_a <= 1'b0;
			interlace_ctrl_b <= 1'b0;
		end
		else
		begin
			v_amp_eff        <= next_vamp;
			interlace_ctrl_a <= ctrl[`VTB_C_ILA];
			interlace_ctrl_b <= ctrl[`VTB_C_ILB];
		end
	end

	height_525_a: assert property (std525 && !ctrl[`VTB_C_VRED]
		|=> v_amp_eff == 9'((15'($past(geo[0])) * 15'h030) / 15'h00a))
		else $error("525 height scaling wrong");
	reduce_a: assert property (!std525 && ctrl[`VTB_C_VRED]
		|=> v_amp_eff == 9'((15'($past(geo[0])) * 15'h01e) / 15'h00a))
		else $error("reduced height scaling wrong");

	assign v_lin    = geo[1];
	assign v_breath = geo[2];
	assign v_pos    = geo[3];
	assign ew_amp   = geo[4];
	assign h_amp    = geo[5];
	assign corner   = geo[6];
	assign tilt     = geo[7];
endmodule : vtb_vertical_timebase
`default_nettype wire
